//--- src/pause_map_defs.svh
// Register offsets, reset values and field positions for the PAUSE address and DSCP map bank.
// Assumes a 16-bit register port with byte addresses; included by its bare name.
`ifndef PAUSE_MAP_DEFS_SVH
`define PAUSE_MAP_DEFS_SVH

`define OFF_SRC_ADDR_HIGH   12'h010
`define OFF_SRC_ADDR_MID    12'h012
`define OFF_SRC_ADDR_LOW    12'h014
`define OFF_MAP_0_7         12'h016
`define OFF_MAP_8_15        12'h018
`define OFF_MAP_16_23       12'h01a
`define MAP_RESET           16'h0000
`define MAP_REGS            3
`define ENTRIES_PER_REG     8
`define TOS_DSCP_MSB        7
`define TOS_DSCP_LSB        2
`define DSCP_REG_MSB        5
`define DSCP_REG_LSB        3
`define DSCP_SLOT_MSB       2
`define DSCP_SLOT_LSB       0

`endif

//--- src/pause_map_pkg.sv
// Types shared by the PAUSE address and DSCP map bank.
// Assumes nothing beyond the defs header.
package pause_map_pkg;

   // Register access request from the switch host side.
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [11:0] addr;
      logic [15:0] wdata;
   } reg_req_type;

   // Classifier lookup request for one ingress frame.
   typedef struct packed {
      logic       valid;
      logic       is_ip;
      logic [7:0] tos;
   } lookup_req_type;

   // Classifier answer.
   typedef struct packed {
      logic       valid;
      logic       hit;
      logic [1:0] prio;
   } lookup_rsp_type;

endpackage : pause_map_pkg

//--- src/dscp_prio_lookup.sv
// DSCP to priority lookup over the packed map entries.
// Assumes the map vector is held in the caller's registers; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "pause_map_defs.svh"

module dscp_prio_lookup
   import pause_map_pkg::*;
#(
   parameter int MAP_REGS = `MAP_REGS
)(
   // Map contents, one 16-bit word per register.
   input  wire logic [MAP_REGS*16-1:0] map_i,
   // Code to look up.
   input  wire logic [5:0]             dscp_i,
   // Result.
   output logic                        covered_o,
   output logic [1:0]                  prio_o
);

   logic [2:0] reg_sel;
   logic [2:0] slot;
   logic [15:0] word;

   // Split the code into a register index and a bit-pair slot within it.
   always_comb
   begin
      reg_sel   = dscp_i[`DSCP_REG_MSB:`DSCP_REG_LSB];
      slot      = dscp_i[`DSCP_SLOT_MSB:`DSCP_SLOT_LSB];
      covered_o = (32'(reg_sel) < MAP_REGS);
      word      = '0;
      if (covered_o)
      begin
         word = map_i[reg_sel*16 +: 16];
      end
      prio_o = word[slot*2 +: 2]; // R7
   end

endmodule : dscp_prio_lookup
`default_nettype wire

//--- src/pause_mac_and_dscp_priority_map.sv
// Configuration bank: PAUSE frame source address and the DSCP priority map for codes 0..23.
// Assumes a synchronous 16-bit register port from the switch core and a classifier on MCLK_I.
`timescale 1ns/1ps
`default_nettype none
`include "pause_map_defs.svh"

// Function
// R1: Offset 0x010 holds station address bits 47:32, read and write.
// R2: Offset 0x012 holds station address bits 31:16, read and write.
// R3: Offset 0x014 holds station address bits 15:0, read and write.
// R4: PAUSE frames take the 48-bit address built from the three registers as source.
// R5: Each IP frame gets a 2-bit priority from the entry chosen by its 6-bit DSCP code.
// R6: The DSCP code is bits 7:2 of the IPv4 TOS or IPv6 traffic class byte.
// R7: In each map register bits 1:0 serve the lowest code, rising by pairs up to 15:14.
// R8: Offset 0x016 maps codes 0 to 7.
// R9: Offset 0x018 maps codes 8 to 15.
// R10: Offset 0x01a maps codes 16 to 23.
// R11: Every map entry is read and write and resets to zero.
// R12: Register writes act on the next frame with no reset needed.
// R13: Frames without an IP header are not classified through the map.
module pause_mac_and_dscp_priority_map
   import pause_map_pkg::*;
#(
   parameter logic [15:0] ADDR_HIGH_RESET = 16'h0200, // Arbitrary value.
   parameter logic [15:0] ADDR_MID_RESET  = 16'h0000, // Arbitrary value.
   parameter logic [15:0] ADDR_LOW_RESET  = 16'h0001  // Arbitrary value.
)(
   // Clock and reset.
   input  wire logic           MCLK_I,
   input  wire logic           SYS_RST_I,
   // Register port.
   input  wire reg_req_type    REG_REQ_I,
   output logic [15:0]         REG_RDATA_O,
   output logic                REG_RVALID_O,
   output logic                REG_ERR_O,
   // Classifier lookup.
   input  wire lookup_req_type LOOKUP_I,
   output lookup_rsp_type      LOOKUP_O,
   // PAUSE generator source address.
   output logic [47:0]         PAUSE_SRC_ADDR_O
);

   // Register layout, in offset order:
   //   0x010  station address bits 47:32.
   //   0x012  station address bits 31:16.
   //   0x014  station address bits 15:0.
   //   0x016  priorities for codes 0 to 7.
   //   0x018  priorities for codes 8 to 15.
   //   0x01a  priorities for codes 16 to 23.
   // Each map word holds eight two-bit entries, the lowest code in bits 1:0.
   // Codes 24 to 63 live in a neighbouring bank, so this one reports no hit
   // for them and the classifier must merge the answers of both banks.
   // Every access is a whole 16-bit word; an odd offset is treated as
   // unmapped, so byte writes from a narrow host must be merged upstream.
   // Answers come one cycle after the request on both ports, and a write
   // is visible to a read or a lookup taken on the very next edge.
   // The PAUSE source follows the registers with one extra cycle of delay.
   // Reset gives the map all zeros, the lowest priority for every code, and
   // the station address the values of the three reset parameters; software
   // is expected to load a real address before it enables flow control.

   // Station address words as software sees them.
   logic [15:0]                  pause_source_addr_high;
   logic [15:0]                  pause_source_addr_mid;
   logic [15:0]                  pause_source_addr_low;
   // Map words packed side by side, lowest codes in the lowest word.
   wire logic [`MAP_REGS*16-1:0] map;
   // Write strobes, one per register word.
   logic                         wr_high;
   logic                         wr_mid;
   logic                         wr_low;
   wire logic [`MAP_REGS-1:0]    wr_map;
   // Register port decode and read side.
   logic                         access;
   logic                         hit_map;
   logic [1:0]                   map_idx;
   logic [15:0]                  next_rdata;
   logic                         next_err;
   // Lookup side.
   logic [5:0]                   dscp;
   logic                         covered;
   logic [1:0]                   prio;
   logic                         classify;

   // A request is a read or a write; the port never raises both at once.
   assign access = REG_REQ_I.rd || REG_REQ_I.wr;

   // Decode which map register an address selects.
   always_comb
   begin
      hit_map = 1'b1;
      map_idx = 2'h0;
      case (REG_REQ_I.addr)
         `OFF_MAP_0_7:   map_idx = 2'h0; // R8
         `OFF_MAP_8_15:  map_idx = 2'h1; // R9
         `OFF_MAP_16_23: map_idx = 2'h2; // R10
         default:        hit_map = 1'b0;
      endcase
   end

   // Station address write strobes; an unmapped offset raises none, so the
   // write is dropped rather than aliased onto a real register.
   always_comb
   begin
      wr_high = 1'b0;
      wr_mid  = 1'b0;
      wr_low  = 1'b0;
      if (REG_REQ_I.wr)
      begin
         case (REG_REQ_I.addr)
            `OFF_SRC_ADDR_HIGH: wr_high = 1'b1; // R1
            `OFF_SRC_ADDR_MID:  wr_mid  = 1'b1; // R2
            `OFF_SRC_ADDR_LOW:  wr_low  = 1'b1; // R3
            default:            ;
         endcase
      end
   end

   // High address word; a write lands on the next edge.
   always_ff @(posedge MCLK_I)
   begin
      if (SYS_RST_I)
      begin
         pause_source_addr_high <= ADDR_HIGH_RESET;
      end
      else if (wr_high)
      begin
         pause_source_addr_high <= REG_REQ_I.wdata; // R1
      end
   end

   // Middle address word.
   always_ff @(posedge MCLK_I)
   begin
      if (SYS_RST_I)
      begin
         pause_source_addr_mid <= ADDR_MID_RESET;
      end
      else if (wr_mid)
      begin
         pause_source_addr_mid <= REG_REQ_I.wdata; // R2
      end
   end

   // Low address word.
   always_ff @(posedge MCLK_I)
   begin
      if (SYS_RST_I)
      begin
         pause_source_addr_low <= ADDR_LOW_RESET;
      end
      else if (wr_low)
      begin
         pause_source_addr_low <= REG_REQ_I.wdata; // R3
      end
   end

   // Map registers, one per group of eight codes. Each word lives in its own
   // generate scope so that no two processes write the same variable.
   genvar g;
   generate
      for (g = 0; g < `MAP_REGS; g++)
      begin : g_map
         logic [15:0] word;

         assign wr_map[g] = REG_REQ_I.wr && hit_map && (32'(map_idx) == g);

         always_ff @(posedge MCLK_I)
         begin
            if (SYS_RST_I)
            begin
               word <= `MAP_RESET; // R11
            end
            else if (wr_map[g])
            begin
               word <= REG_REQ_I.wdata; // R11
            end
         end

         assign map[g*16 +: 16] = word;
      end
   endgenerate

   // Read mux; unmapped offsets read zero and flag an error.
   always_comb
   begin
      next_rdata = 16'h0000;
      next_err   = 1'b0;
      case (REG_REQ_I.addr)
         `OFF_SRC_ADDR_HIGH: next_rdata = pause_source_addr_high; // R1
         `OFF_SRC_ADDR_MID:  next_rdata = pause_source_addr_mid;  // R2
         `OFF_SRC_ADDR_LOW:  next_rdata = pause_source_addr_low;  // R3
         default:
         begin
            if (hit_map)
            begin
               next_rdata = map[map_idx*16 +: 16]; // R11
            end
            else
            begin
               next_err = 1'b1;
            end
         end
      endcase
   end

   // Answer strobe: every request, mapped or not, gets exactly one, so a host
   // never waits on an offset that this bank does not own.
   always_ff @(posedge MCLK_I)
   begin
      if (SYS_RST_I)
      begin
         REG_RVALID_O <= 1'b0;
      end
      else
      begin
         REG_RVALID_O <= access;
      end
   end

   // Read data stands only with a read answer and is zero otherwise, so the
   // answers of several banks can be merged by a plain OR.
   always_ff @(posedge MCLK_I)
   begin
      if (SYS_RST_I)
      begin
         REG_RDATA_O <= 16'h0000;
      end
      else
      begin
         REG_RDATA_O <= REG_REQ_I.rd ? next_rdata : 16'h0000;
      end
   end

   // The error flag rides with the answer strobe for reads and writes alike.
   always_ff @(posedge MCLK_I)
   begin
      if (SYS_RST_I)
      begin
         REG_ERR_O <= 1'b0;
      end
      else
      begin
         REG_ERR_O <= access && next_err;
      end
   end

   // Address follows the registers every cycle, so a new value serves the next frame.
   always_ff @(posedge MCLK_I)
   begin
      if (SYS_RST_I)
      begin
         PAUSE_SRC_ADDR_O <= {ADDR_HIGH_RESET, ADDR_MID_RESET, ADDR_LOW_RESET};
      end
      else
      begin
         PAUSE_SRC_ADDR_O <= {pause_source_addr_high, pause_source_addr_mid,
                              pause_source_addr_low}; // R4 R12
      end
   end

   // Code is the upper six bits of the TOS or traffic class byte.
   // The two low bits of that byte are not part of the code and are ignored.
   assign dscp = LOOKUP_I.tos[`TOS_DSCP_MSB:`TOS_DSCP_LSB]; // R6

   dscp_prio_lookup #(
      .MAP_REGS (`MAP_REGS)
   ) u_lookup (
      .map_i     (map),
      .dscp_i    (dscp),
      .covered_o (covered),
      .prio_o    (prio)
   );

   // Only IP frames are classified here; the flag is formed once and shared by
   // the hit and the priority so that both always agree.
   assign classify = LOOKUP_I.valid && LOOKUP_I.is_ip; // R13

   // Lookup answer; non-IP frames and codes beyond this bank report no hit,
   // leaving the classifier to use its other sources. A non-IP frame also
   // reports priority zero, so a consumer that ignores the hit flag still
   // sees the lowest class rather than a stale map entry.
   always_ff @(posedge MCLK_I)
   begin
      if (SYS_RST_I)
      begin
         LOOKUP_O <= '0;
      end
      else if (classify)
      begin
         LOOKUP_O.valid <= 1'b1;
         LOOKUP_O.hit   <= covered; // R13
         LOOKUP_O.prio  <= prio; // R5 R12
      end
      else
      begin
         LOOKUP_O.valid <= LOOKUP_I.valid;
         LOOKUP_O.hit   <= 1'b0; // R13
         LOOKUP_O.prio  <= 2'h0;
      end
   end

endmodule : pause_mac_and_dscp_priority_map
`default_nettype wire

//--- test/pause_map_sva.sv
// Checker for the PAUSE address and DSCP priority map bank.
// Assumes it is bound to the bank's top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "pause_map_defs.svh"
module pause_map_sva
   import pause_map_pkg::*;
(
   // Watched ports.
   input wire logic           MCLK_I,
   input wire logic           SYS_RST_I,
   input wire reg_req_type    REG_REQ_I,
   input wire logic [15:0]    REG_RDATA_O,
   input wire logic           REG_RVALID_O,
   input wire logic           REG_ERR_O,
   input wire lookup_req_type LOOKUP_I,
   input wire lookup_rsp_type LOOKUP_O,
   input wire logic [47:0]    PAUSE_SRC_ADDR_O
);
   default clocking dcb @(posedge MCLK_I);
   endclocking
   default disable iff (SYS_RST_I);
   // A high address write lands on the PAUSE source two edges later.
   sequence hi_wr_s;
      REG_REQ_I.wr && REG_REQ_I.addr == `OFF_SRC_ADDR_HIGH;
   endsequence
   // A mapped write followed, after one cycle with no write, by a read of the same place.
   sequence wr_rd_s;
      REG_REQ_I.wr && !REG_REQ_I.addr[0]
         && REG_REQ_I.addr inside {[`OFF_SRC_ADDR_HIGH:`OFF_MAP_16_23]}
      ##1 !REG_REQ_I.wr
      ##1 REG_REQ_I.rd && REG_REQ_I.addr == $past(REG_REQ_I.addr, 2);
   endsequence
   a_req_answered: assert property ((REG_REQ_I.rd || REG_REQ_I.wr) |=> REG_RVALID_O)
      else $error("register request not answered");
   a_write_reads_back: assert property (wr_rd_s |=> REG_RDATA_O == $past(REG_REQ_I.wdata, 3))
      else $error("read after write mismatch");
   a_pause_follows: assert property (
      hi_wr_s |=> ##1 PAUSE_SRC_ADDR_O[47:32] == $past(REG_REQ_I.wdata, 2))
      else $error("pause address not updated");
   a_lookup_answered: assert property (LOOKUP_I.valid |=> LOOKUP_O.valid)
      else $error("lookup not answered");
   a_lookup_idle: assert property (!LOOKUP_I.valid |=> !LOOKUP_O.valid)
      else $error("lookup answer without frame");
   a_non_ip_ignored: assert property (
      LOOKUP_I.valid && !LOOKUP_I.is_ip |=> !LOOKUP_O.hit && LOOKUP_O.prio == 2'h0)
      else $error("non IP frame classified");
   a_high_code_miss: assert property (
      LOOKUP_I.valid && LOOKUP_I.is_ip && LOOKUP_I.tos[7:2] > 6'h17 |=> !LOOKUP_O.hit)
      else $error("uncovered code hit");
   a_low_code_hit: assert property (
      LOOKUP_I.valid && LOOKUP_I.is_ip && LOOKUP_I.tos[7:2] < 6'h18 |=> LOOKUP_O.hit)
      else $error("covered code missed");
endmodule : pause_map_sva
bind pause_mac_and_dscp_priority_map pause_map_sva u_sva (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
   .REG_REQ_I(REG_REQ_I), .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
   .REG_ERR_O(REG_ERR_O), .LOOKUP_I(LOOKUP_I), .LOOKUP_O(LOOKUP_O),
   .PAUSE_SRC_ADDR_O(PAUSE_SRC_ADDR_O));
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the PAUSE address and DSCP priority map bank.
// Assumes the bank answers one cycle after it takes a request on either port.
`timescale 1ns/1ps
`default_nettype none
`include "pause_map_defs.svh"
module tb_top
   import pause_map_pkg::*;
;
   logic           mclk = 1'b0;
   logic           rst = 1'b1;
   reg_req_type    req = '0;
   lookup_req_type lk = '0;
   logic [15:0]    rdata;
   logic           rvalid;
   logic           err;
   lookup_rsp_type rsp;
   logic [47:0]    pause;
   logic [2:0]     e_lk;
   int             fails = 0;
   int             n_tests = 0;
   logic [15:0]    v [6] = '{16'h0a0b, 16'h0c0d, 16'h0e0f, 16'he4b1, 16'h1b4e, 16'h9c63};
   // A 4 ns period.
   always #2 mclk = ~mclk;
   // Reset values are set apart from the defaults so a stuck default shows.
   pause_mac_and_dscp_priority_map #(.ADDR_HIGH_RESET(16'h1357), .ADDR_MID_RESET(16'h2468),
      .ADDR_LOW_RESET(16'h0abc)) DUT (.MCLK_I(mclk), .SYS_RST_I(rst), .REG_REQ_I(req),
      .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .REG_ERR_O(err), .LOOKUP_I(lk),
      .LOOKUP_O(rsp), .PAUSE_SRC_ADDR_O(pause));
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One access; the answer stands a single cycle, so it is read at the next falling edge.
   // A write answer must carry zero data, so the data is compared for both kinds.
   task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d,
                      input logic [16:0] e);
      @(negedge mclk);
      req = '{rd: !w, wr: w, addr: a, wdata: d};
      @(negedge mclk);
      req = '0;
      chk(48'({rvalid, err}), 48'({1'b1, e[16]}));
      chk(48'(rdata), 48'(e[15:0]));
   endtask : acc
   task automatic look(input logic ip, input logic [7:0] t, input logic [2:0] e);
      @(negedge mclk);
      lk = '{valid: 1'b1, is_ip: ip, tos: t};
      @(negedge mclk);
      lk = '0;
      chk(48'(rsp), 48'({1'b1, e}));
   endtask : look
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   // Watchdog: a stuck run still ends with a verdict.
   initial
   begin
      #20000;
      fails++;
      give_verdict();
   end
   // Main sequence; the code sweep sets the low TOS bits to one so a wrong code slice shows.
   initial
   begin
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      chk(pause, 48'h1357_2468_0abc);
      for (int i = 0; i < 3; i++)
         acc(1'b0, `OFF_MAP_0_7 + 12'(2 * i), 16'h0, 17'h0);
      acc(1'b0, `OFF_SRC_ADDR_MID, 16'h0, 17'h02468);
      acc(1'b0, 12'h01c, 16'h0, 17'h10000);
      for (int i = 0; i < 6; i++)
         acc(1'b1, `OFF_SRC_ADDR_HIGH + 12'(2 * i), v[i], 17'h0);
      for (int i = 5; i >= 0; i--)
         acc(1'b0, `OFF_SRC_ADDR_HIGH + 12'(2 * i), 16'h0, {1'b0, v[i]});
      // An odd offset is refused and must not alias onto the high word.
      acc(1'b1, 12'h011, 16'hffff, 17'h10000);
      acc(1'b0, `OFF_SRC_ADDR_HIGH, 16'h0, {1'b0, v[0]});
      chk(pause, 48'h0a0b_0c0d_0e0f);
      for (int d = 0; d < 26; d++)
      begin
         e_lk = d < 24 ? {1'b1, v[3 + d / 8][2 * (d % 8) +: 2]} : 3'h0;
         look(1'b1, {6'(d), 2'b11}, e_lk);
      end
      look(1'b1, 8'hff, 3'h0);
      // Code 2 maps to a non-zero entry, so a leaked priority would show.
      look(1'b0, 8'h08, 3'h0);
      acc(1'b1, `OFF_MAP_0_7, 16'h000c, 17'h0);
      look(1'b1, 8'h04, 3'h7);
      // A reset in mid-run must restore the reset values over the values written above.
      @(negedge mclk);
      rst = 1'b1;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      chk(pause, 48'h1357_2468_0abc);
      acc(1'b0, `OFF_MAP_8_15, 16'h0, 17'h0);
      acc(1'b0, `OFF_SRC_ADDR_HIGH, 16'h0, 17'h01357);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
